// [tecu_regs.vh]
`ifndef TECU_REGS_VH
`define TECU_REGS_VH

// register byte offsets
`define TECU_CTRL0_OFS 12'h000
`define TECU_CTRL1_OFS 12'h004
`define TECU_CAP0_OFS 12'h008
`define TECU_CAP1_OFS 12'h00c
`define TECU_FLAG_OFS 12'h010
`define TECU_MASK_OFS 12'h014
`define TECU_PIN_OFS 12'h018
`define TECU_STAT_OFS 12'h01c

// capture_mode_select codes
`define TECU_MODE_OFF 4'h0
`define TECU_MODE_FALL 4'h4
`define TECU_MODE_RISE 4'h5
`define TECU_MODE_RISE4 4'h6
`define TECU_MODE_RISE16 4'h7

// prescaler terminal counts
`define TECU_PRESC4_LAST 4'h3
`define TECU_PRESC16_LAST 4'hf

// pin register fields
`define TECU_PIN_DIR_LSB 0
`define TECU_PIN_DATA_LSB 8

// status register fields
`define TECU_STAT_PRESC1_LSB 4
`define TECU_STAT_LEVEL_LSB 8

// reset values
`define TECU_CTRL_RST 4'h0
`define TECU_DIR_RST 2'h3
`define TECU_DATA_RST 2'h0
`define TECU_FLAG_RST 2'h0
`define TECU_MASK_RST 2'h0

`endif

// [tecu_chan.v]
`timescale 1ns/1ns
`include "tecu_regs.vh"

module tecu_chan
(
    // clock and reset
    input wire pclk,
    input wire presetn,
    // configuration and inputs
    input wire [3:0] capture_mode_select,
    input wire pin_level,
    input wire [7:0] sixteen_bit_count_high,
    input wire [7:0] sixteen_bit_count_low,
    // results
    output reg capture_event,
    output reg [7:0] capture_value_high,
    output reg [7:0] capture_value_low,
    output reg [3:0] presc_count
);

reg prev_level;
reg next_event;
reg [3:0] next_presc;
wire rise = pin_level & ~prev_level;
wire fall = ~pin_level & prev_level;

// a change between the two prescaled modes keeps the count, so
// the first event after it may come early
always @*
begin
    next_event = 1'b0;
    next_presc = presc_count;
    case (capture_mode_select)
        `TECU_MODE_FALL:
            next_event = fall;
        `TECU_MODE_RISE:
            next_event = rise;
        `TECU_MODE_RISE4:
            if (rise)
            begin
                if (presc_count == `TECU_PRESC4_LAST)
                begin
                    next_presc = 4'h0;
                    next_event = 1'b1;
                end
                else
                    next_presc = presc_count + 4'h1;
            end
        `TECU_MODE_RISE16:
            if (rise)
            begin
                if (presc_count == `TECU_PRESC16_LAST)
                begin
                    next_presc = 4'h0;
                    next_event = 1'b1;
                end
                else
                    next_presc = presc_count + 4'h1;
            end
        default:
            next_presc = 4'h0;
    endcase
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prev_level <= 1'b0;
        capture_event <= 1'b0;
        presc_count <= 4'h0;
        capture_value_high <= 8'h00;
        capture_value_low <= 8'h00;
    end
    else
    begin
        prev_level <= pin_level;
        capture_event <= next_event;
        presc_count <= next_presc;
        if (next_event)
        begin
            // both bytes in one edge; older value simply lost
            capture_value_high <= sixteen_bit_count_high;
            capture_value_low <= sixteen_bit_count_low;
        end
    end
end

endmodule

// [tecu_top.v]
// Operation
// - two identical independent capture units, each with own control and flag.
// - qualifying event loads the 16-bit timer count into the capture pair.
// - mode picks falling, rising, every 4th or every 16th rising edge.
// - every capture sets that unit's interrupt flag.
// - flag stays set until software clears it; hardware never clears it.
// - a newer capture overwrites an unread older value.
// - pin used as output still feeds written port data to capture.
// - changing capture mode may raise a spurious capture flag.
// - prescaler counter held cleared when off or not capturing.
// - every reset clears the prescaler counter.
// - switching between prescaler settings keeps the counter.
// - capture keeps running while the core sleeps on an external count.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ns
`include "tecu_regs.vh"

module tecu_top
(
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb request
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // apb answer
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // shared timer count
    input wire [7:0] sixteen_bit_count_high,
    input wire [7:0] sixteen_bit_count_low,
    // capture pins, one bit per unit
    input wire [1:0] capture_pin_in,
    output reg [1:0] capture_pin_out,
    output reg [1:0] capture_pin_oe,
    // interrupt
    output reg irq
);

// control and configuration
reg [3:0] capture_unit_control0;
reg [3:0] capture_unit_control1;
reg [1:0] pin_direction_bit;
reg [1:0] port_data;
reg [1:0] peripheral_flag_register;
reg [1:0] peripheral_enable_register;

// pin synchroniser
reg [1:0] pin_sync1;
reg [1:0] pin_sync2;

// unit results
wire [1:0] capture_event;
wire [7:0] cap0_high;
wire [7:0] cap0_low;
wire [7:0] cap1_high;
wire [7:0] cap1_low;
wire [3:0] presc0;
wire [3:0] presc1;
wire [1:0] pin_level;

// bus decode
wire setup_phase = psel & ~penable;
wire access_done = psel & penable & pready;
wire wr_done = access_done & pwrite;
wire rd_done = access_done & ~pwrite;
reg [31:0] next_rdata;
reg next_slverr;
reg [1:0] flag_clear;
reg [1:0] next_flags;

// two flops; only the second is looked at
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pin_sync1 <= 2'h0;
        pin_sync2 <= 2'h0;
    end
    else
    begin
        pin_sync1 <= capture_pin_in;
        pin_sync2 <= pin_sync1;
    end
end

// an output pin is seen at its own written level
assign pin_level[0] = pin_direction_bit[0] ? pin_sync2[0] : port_data[0];
assign pin_level[1] = pin_direction_bit[1] ? pin_sync2[1] : port_data[1];

// no clock gating here: capture needs only pclk and the count
// input, so it runs on pclk whatever clock the timer uses
tecu_chan u_chan0
(
    .pclk(pclk),
    .presetn(presetn),
    .capture_mode_select(capture_unit_control0),
    .pin_level(pin_level[0]),
    .sixteen_bit_count_high(sixteen_bit_count_high),
    .sixteen_bit_count_low(sixteen_bit_count_low),
    .capture_event(capture_event[0]),
    .capture_value_high(cap0_high),
    .capture_value_low(cap0_low),
    .presc_count(presc0)
);

tecu_chan u_chan1
(
    .pclk(pclk),
    .presetn(presetn),
    .capture_mode_select(capture_unit_control1),
    .pin_level(pin_level[1]),
    .sixteen_bit_count_high(sixteen_bit_count_high),
    .sixteen_bit_count_low(sixteen_bit_count_low),
    .capture_event(capture_event[1]),
    .capture_value_high(cap1_high),
    .capture_value_low(cap1_low),
    .presc_count(presc1)
);

// read data is latched at setup; an unmapped address errors
always @*
begin
    next_rdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr)
        `TECU_CTRL0_OFS:
            next_rdata[3:0] = capture_unit_control0;
        `TECU_CTRL1_OFS:
            next_rdata[3:0] = capture_unit_control1;
        `TECU_CAP0_OFS:
            next_rdata[15:0] = {cap0_high, cap0_low};
        `TECU_CAP1_OFS:
            next_rdata[15:0] = {cap1_high, cap1_low};
        `TECU_FLAG_OFS:
            next_rdata[1:0] = peripheral_flag_register;
        `TECU_MASK_OFS:
            next_rdata[1:0] = peripheral_enable_register;
        `TECU_PIN_OFS:
        begin
            next_rdata[`TECU_PIN_DIR_LSB +: 2] = pin_direction_bit;
            next_rdata[`TECU_PIN_DATA_LSB +: 2] = port_data;
        end
        `TECU_STAT_OFS:
        begin
            next_rdata[3:0] = presc0;
            next_rdata[`TECU_STAT_PRESC1_LSB +: 4] = presc1;
            next_rdata[`TECU_STAT_LEVEL_LSB +: 2] = pin_level;
        end
        default:
            next_slverr = 1'b1;
    endcase
end

// only bits that the read actually reported are cleared, so an
// event between setup and access is kept; set beats clear
always @*
begin
    flag_clear = 2'h0;
    if (rd_done && paddr == `TECU_FLAG_OFS)
        flag_clear = prdata[1:0];
    next_flags = (peripheral_flag_register & ~flag_clear) | capture_event;
end

// apb answer: one wait-free access phase
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata <= 32'h0000_0000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
    else
    begin
        pready <= setup_phase;
        if (setup_phase)
        begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= next_slverr;
        end
        else if (access_done)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end
end

// software-written configuration
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        capture_unit_control0 <= `TECU_CTRL_RST;
        capture_unit_control1 <= `TECU_CTRL_RST;
        pin_direction_bit <= `TECU_DIR_RST;
        port_data <= `TECU_DATA_RST;
        peripheral_enable_register <= `TECU_MASK_RST;
    end
    else if (wr_done)
    begin
        case (paddr)
            `TECU_CTRL0_OFS:
                capture_unit_control0 <= pwdata[3:0];
            `TECU_CTRL1_OFS:
                capture_unit_control1 <= pwdata[3:0];
            `TECU_MASK_OFS:
                peripheral_enable_register <= pwdata[1:0];
            `TECU_PIN_OFS:
            begin
                pin_direction_bit <= pwdata[`TECU_PIN_DIR_LSB +: 2];
                port_data <= pwdata[`TECU_PIN_DATA_LSB +: 2];
            end
            default:
                port_data <= port_data;
        endcase
    end
end

// sticky flags; no hardware path ever clears them
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        peripheral_flag_register <= `TECU_FLAG_RST;
    else
        peripheral_flag_register <= next_flags;
end

// pin drivers and interrupt, all straight from flops
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        capture_pin_out <= 2'h0;
        capture_pin_oe <= 2'h0;
        irq <= 1'b0;
    end
    else
    begin
        capture_pin_out <= port_data;
        capture_pin_oe <= ~pin_direction_bit;
        irq <= |(peripheral_flag_register & peripheral_enable_register);
    end
end

endmodule

// [tecu_top_properties.sv]
`timescale 1ns/1ns
`include "tecu_regs.vh"
module tecu_chk
(
    // bus
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // pins and interrupt
    input wire [1:0] capture_pin_out,
    input wire [1:0] capture_pin_oe,
    input wire irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && pready;
    wire wpin = acc && pwrite && paddr == `TECU_PIN_OFS;
    wire rdf = !pwrite && paddr == `TECU_FLAG_OFS;
    wire clr = acc && (rdf || pwrite && paddr == `TECU_MASK_OFS);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    property p_ready;
        s_setup |=> s_access;
    endproperty
    a_ready: assert property (p_ready) else $error("late answer");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("long ready");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("stray error");
    property p_dir;
        wpin |-> ##2 capture_pin_oe == ~$past(pwdata[1:0], 2);
    endproperty
    a_dir: assert property (p_dir) else $error("bad enable");
    property p_data;
        wpin |-> ##2 capture_pin_out == $past(pwdata[9:8], 2);
    endproperty
    a_data: assert property (p_data) else $error("bad data");
    property p_mask;
        acc && pwrite && paddr == `TECU_MASK_OFS && pwdata[1:0] == 0
            |-> ##2 !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("masked irq");
    property p_hold;
        irq && !clr && !$past(clr) |=> irq;
    endproperty
    a_hold: assert property (p_hold) else $error("irq lost");
    property p_unmap;
        acc && !pwrite && paddr > `TECU_STAT_OFS |-> pslverr && !prdata;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule
bind tecu_top tecu_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .capture_pin_out,
    .capture_pin_oe, .irq);

// [tecu_src.sv]
`timescale 1ns/1ns
module tecu_src
(
    // core clock
    input wire pclk,
    // pin levels toward the unit
    output reg [1:0] capture_pin_in
);
    initial capture_pin_in = 2'h0;
    // long hold keeps every edge countable
    task set(input int u, input bit v);
        @(posedge pclk);
        capture_pin_in[u] <= v;
        repeat (5) @(posedge pclk);
    endtask
    task pulse(input int u, input int n);
        repeat (n)
        begin
            set(u, 1'b1);
            set(u, 1'b0);
        end
    endtask
endmodule

// [tecu_top_tb.sv]
`timescale 1ns/1ns
`include "tecu_regs.vh"
module tecu_top_tb;
    reg pclk = 0;
    reg presetn = 0;
    reg psel = 0;
    reg penable = 0;
    reg pwrite = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0;
    reg [15:0] cnt = 0;
    reg [31:0] q;
    reg e;
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [1:0] pin, pin_out, pin_oe;
    int miscompares = 0;
    int check_count = 0;
    always #4 pclk = ~pclk;
    tecu_top i_tecu_top (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sixteen_bit_count_high(cnt[15:8]),
        .sixteen_bit_count_low(cnt[7:0]), .capture_pin_in(pin),
        .capture_pin_out(pin_out), .capture_pin_oe(pin_oe), .irq);
    tecu_src i_tecu_src (.pclk, .capture_pin_in(pin));
    task close_out;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input [31:0] g, input [31:0] x);
        check_count++;
        if (g !== x)
        begin
            $display("Error %0t: got %h expected %h", $time, g, x);
            miscompares++;
        end
    endtask
    task apb(input [11:0] a, input w, input [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (pready !== 1)
        begin
            miscompares++;
            close_out;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        apb(a, 1, d);
    endtask
    task rd(input [11:0] a, input [31:0] x);
        apb(a, 0, 0);
        chk(q, x);
    endtask
    task mode(input [3:0] m);
        wr(`TECU_CTRL0_OFS, 0);
        wr(`TECU_CTRL0_OFS, m);
        rd(`TECU_FLAG_OFS, 0);
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        rd(`TECU_PIN_OFS, 3);
        rd(12'h020, 0);
        chk(e, 1);
        wr(`TECU_MASK_OFS, 1);
        cnt <= 16'h1234;
        mode(`TECU_MODE_RISE);
        i_tecu_src.pulse(0, 1);
        rd(`TECU_CAP0_OFS, 16'h1234);
        chk(irq, 1);
        rd(`TECU_FLAG_OFS, 1);
        rd(`TECU_FLAG_OFS, 0);
        i_tecu_src.pulse(0, 1);
        cnt <= 16'h5678;
        i_tecu_src.pulse(0, 1);
        rd(`TECU_CAP0_OFS, 16'h5678);
        rd(`TECU_FLAG_OFS, 1);
        $display("test basic capture done");
        mode(`TECU_MODE_FALL);
        i_tecu_src.set(0, 1);
        cnt <= 16'h2222;
        i_tecu_src.set(0, 0);
        rd(`TECU_CAP0_OFS, 16'h2222);
        rd(`TECU_FLAG_OFS, 1);
        $display("test falling edge done");
        for (int i = 0; i < 2; i++)
        begin
            mode(`TECU_MODE_RISE4 + i);
            i_tecu_src.pulse(0, i ? 15 : 3);
            rd(`TECU_FLAG_OFS, 0);
            i_tecu_src.pulse(0, 1);
            rd(`TECU_FLAG_OFS, 1);
        end
        mode(`TECU_MODE_RISE4);
        i_tecu_src.pulse(0, 2);
        wr(`TECU_CTRL0_OFS, `TECU_MODE_RISE16);
        rd(`TECU_STAT_OFS, 2);
        wr(`TECU_CTRL0_OFS, 9);
        rd(`TECU_STAT_OFS, 0);
        wr(`TECU_CTRL0_OFS, `TECU_MODE_RISE4);
        i_tecu_src.pulse(0, 2);
        presetn <= 0;
        repeat (5) @(posedge pclk);
        presetn <= 1;
        rd(`TECU_STAT_OFS, 0);
        $display("test prescaler done");
        wr(`TECU_CTRL0_OFS, `TECU_MODE_RISE);
        wr(`TECU_CTRL1_OFS, `TECU_MODE_RISE);
        cnt <= 16'h4321;
        wr(`TECU_PIN_OFS, 32'h102);
        repeat (2) @(posedge pclk);
        chk(pin_oe, 1);
        rd(`TECU_CAP0_OFS, 16'h4321);
        rd(`TECU_FLAG_OFS, 1);
        wr(`TECU_PIN_OFS, 3);
        wr(`TECU_MASK_OFS, 2);
        cnt <= 16'h9999;
        i_tecu_src.pulse(1, 1);
        chk(irq, 1);
        rd(`TECU_CAP1_OFS, 16'h9999);
        rd(`TECU_CAP0_OFS, 16'h4321);
        wr(`TECU_MASK_OFS, 0);
        rd(`TECU_FLAG_OFS, 2);
        $display("test pins and units done");
        close_out;
    end
endmodule
